// [include/pmd_pkg.sv]
// Package for the peripheral module disable block: register map,
// implemented-bit masks and flat indices of each disable bit.
// Assumes a 32-bit classic Wishbone slave, one word per register.
package pmd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          NUM_REGS   = 5;
  localparam int          FLAT_W     = 8 * NUM_REGS;
  localparam logic [4:0]  CTRL0_ADDR = 5'h00;
  localparam logic [4:0]  CTRL1_ADDR = 5'h04;
  localparam logic [4:0]  CTRL2_ADDR = 5'h08;
  localparam logic [4:0]  CTRL3_ADDR = 5'h0c;
  localparam logic [4:0]  CTRL4_ADDR = 5'h10;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [31:0] BUS_ZERO   = 32'h0000_0000;
  localparam logic [7:0]  SFR_ZERO   = 8'h00;

  // Implemented bits of each control register
  localparam logic [7:0] CTRL0_MASK = 8'hc7;
  localparam logic [7:0] CTRL1_MASK = 8'h87;
  localparam logic [7:0] CTRL2_MASK = 8'h67;
  localparam logic [7:0] CTRL3_MASK = 8'h3f;
  localparam logic [7:0] CTRL4_MASK = 8'hd1;
  localparam logic [FLAT_W-1:0] FLAT_MASK =
    {CTRL4_MASK, CTRL3_MASK, CTRL2_MASK, CTRL1_MASK, CTRL0_MASK};

  // ----------------------------------------------------------------
  // Flat index of each disable bit: register * 8 + bit
  // ----------------------------------------------------------------
  localparam int PIN_CHANGE_IRQ_OFF = 0;
  localparam int REF_CLOCK_OUT_OFF  = 1;
  localparam int MEMORY_CTRL_OFF    = 2;
  localparam int VOLTAGE_REF_OFF    = 6;
  localparam int SYS_CLOCK_GATE_OFF = 7;
  localparam int TIMER0_OFF         = 8;
  localparam int TIMER1_OFF         = 9;
  localparam int TIMER2_OFF         = 10;
  localparam int NUM_OSC_OFF        = 15;
  localparam int ZERO_CROSS_OFF     = 16;
  localparam int COMPARATOR1_OFF    = 17;
  localparam int COMPARATOR2_OFF    = 18;
  localparam int ADC_OFF            = 21;
  localparam int DAC_OFF            = 22;
  localparam int CAPCOMP1_OFF       = 24;
  localparam int CAPCOMP2_OFF       = 25;
  localparam int PWM_THREE_OFF      = 26;
  localparam int PWM_FOUR_OFF       = 27;
  localparam int PWM_FIVE_OFF       = 28;
  localparam int PWM_SIX_OFF        = 29;
  localparam int WAVEFORM_GEN_OFF   = 32;
  localparam int SYNC_SERIAL_OFF    = 36;
  localparam int ASYNC_SERIAL1_OFF  = 38;
  localparam int ASYNC_SERIAL2_OFF  = 39;

  // Modules fed from the peripheral system clock network
  localparam logic [FLAT_W-1:0] SYSCLK_USERS_DEFAULT =
    FLAT_MASK & ~(40'h1 << SYS_CLOCK_GATE_OFF);

  // Bus states of the slave
  typedef enum logic [0:0] {
    PMD_BUS_IDLE = 1'b0,
    PMD_BUS_ACK  = 1'b1
  } pmd_bus_t;

endpackage

// [rtl/pmd_clk_gate.sv]
// Glitch-free clock enables for the gated peripheral clocks.
// Assumes the consumer forms its clock as i_clock AND the enable.
`timescale 1ns/1ps
module pmd_clk_gate
  import pmd_pkg::*;
#(
  parameter int W = FLAT_W
) (
  input  wire logic         i_clock,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_run,
  output logic      [W-1:0] o_clk_en
);

  // ----------------------------------------------------------------
  // Enable flops
  // ----------------------------------------------------------------
  // Falling-edge update: the enable only moves while the clock is low,
  // so AND-gating never cuts a high phase short
  always_ff @(negedge i_clock) begin
    if (i_reset) begin
      o_clk_en <= '1;
    end else begin
      o_clk_en <= i_run;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Moved on the falling edge, so already in place at the next rise
  gate_low_phase_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_clk_en == i_run)
    else $error("Clock enable did not follow its run request");

endmodule

// [rtl/pmd_top.sv]
// Peripheral module disable block: five control registers on a
// Wishbone slave, per-module reset holds, clock enables, register
// read and write gating, and memory controller access gating.
// Assumes a single 250 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps

module pmd_top
  import pmd_pkg::*;
#(
  parameter logic [FLAT_W-1:0] SYSCLK_USERS = SYSCLK_USERS_DEFAULT
) (
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  // Wishbone classic slave
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [4:0]        i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  output logic      [31:0]       o_wb_dat,
  output logic                   o_wb_ack,
  // Peripheral register access, module chosen by flat index
  input  wire logic [5:0]        i_sfr_sel,
  input  wire logic              i_sfr_we,
  input  wire logic [7:0]        i_sfr_rdata,
  output logic                   o_sfr_we,
  output logic      [7:0]        o_sfr_rdata,
  // Memory controller access
  input  wire logic              i_mem_rd,
  input  wire logic              i_mem_wr,
  input  wire logic              i_mem_ctrl_we,
  input  wire logic [7:0]        i_mem_rdata,
  output logic                   o_mem_rd,
  output logic                   o_mem_wr,
  output logic                   o_mem_ctrl_we,
  output logic      [7:0]        o_mem_rdata,
  // Per-module controls, flat index = register * 8 + bit
  output logic      [FLAT_W-1:0] o_mod_reset,
  output logic      [FLAT_W-1:0] o_mod_clk_en,
  output logic      [FLAT_W-1:0] o_pin_route_off,
  output logic                   o_sys_clock_gate_off
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Implemented-bit mask of a register index
  function automatic logic [7:0] impl_mask(input logic [2:0] idx);
    case (idx)
      3'h0:    impl_mask = CTRL0_MASK;
      3'h1:    impl_mask = CTRL1_MASK;
      3'h2:    impl_mask = CTRL2_MASK;
      3'h3:    impl_mask = CTRL3_MASK;
      3'h4:    impl_mask = CTRL4_MASK;
      default: impl_mask = 8'h00;
    endcase
  endfunction

  // Register index of a byte address, NUM_REGS when unmapped
  function automatic logic [2:0] reg_index(input logic [4:0] adr);
    case (adr)
      CTRL0_ADDR: reg_index = 3'h0;
      CTRL1_ADDR: reg_index = 3'h1;
      CTRL2_ADDR: reg_index = 3'h2;
      CTRL3_ADDR: reg_index = 3'h3;
      CTRL4_ADDR: reg_index = 3'h4;
      default:    reg_index = 3'(NUM_REGS);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  pmd_bus_t          bus_q;
  logic [7:0]        ctrl_q [NUM_REGS];
  logic [FLAT_W-1:0] off_flat;
  logic [2:0]        acc_idx;
  logic              bus_req;
  logic              wr_take;

  assign bus_req = i_wb_cyc && i_wb_stb;
  assign acc_idx = reg_index(i_wb_adr);
  // Write takes effect on the edge that raises ack
  assign wr_take = bus_req && i_wb_we && (bus_q == PMD_BUS_IDLE)
                   && i_wb_sel[0];

  // One wait state, ack for one cycle, then dropped
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      bus_q    <= PMD_BUS_IDLE;
      o_wb_ack <= 1'b0;
    end else begin
      case (bus_q)
        PMD_BUS_IDLE: begin
          o_wb_ack <= bus_req;
          bus_q    <= bus_req ? PMD_BUS_ACK : PMD_BUS_IDLE;
        end
        PMD_BUS_ACK: begin
          o_wb_ack <= 1'b0;
          bus_q    <= PMD_BUS_IDLE;
        end
        default: begin
          o_wb_ack <= 1'b0;
          bus_q    <= PMD_BUS_IDLE;
        end
      endcase
    end
  end

  // Read data; unmapped words read zero
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_wb_dat <= BUS_ZERO;
    end else if (bus_req && !i_wb_we && bus_q == PMD_BUS_IDLE
                 && acc_idx < 3'(NUM_REGS)) begin
      o_wb_dat <= {24'h000000, ctrl_q[acc_idx]};
    end else begin
      o_wb_dat <= BUS_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Masking on write keeps unimplemented bits at zero for good
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      for (int r = 0; r < NUM_REGS; r++) begin
        ctrl_q[r] <= CTRL_RESET;
      end
    end else if (wr_take && acc_idx < 3'(NUM_REGS)) begin
      ctrl_q[acc_idx] <= i_wb_dat[7:0] & impl_mask(acc_idx);
    end
  end

  assign off_flat = {ctrl_q[4], ctrl_q[3], ctrl_q[2], ctrl_q[1],
                     ctrl_q[0]} & FLAT_MASK;

  // ----------------------------------------------------------------
  // Module holds
  // ----------------------------------------------------------------
  // Reset hold and pin routing follow the disable bits; a cleared
  // bit returns the module from reset with its power-on values
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_mod_reset          <= '0;
      o_pin_route_off      <= '0;
      o_sys_clock_gate_off <= 1'b0;
    end else begin
      // Each implemented bit holds one module, except the gate bit, which stays zero
      o_mod_reset <= off_flat;
      o_mod_reset[SYS_CLOCK_GATE_OFF] <= 1'b0;
      o_pin_route_off <= off_flat;
      o_pin_route_off[SYS_CLOCK_GATE_OFF] <= 1'b0;
      o_sys_clock_gate_off <= off_flat[SYS_CLOCK_GATE_OFF];
    end
  end

  // ----------------------------------------------------------------
  // Clock enables
  // ----------------------------------------------------------------
  logic [FLAT_W-1:0] run;

  // Disabled modules freeze; the network gate only hits its users
  assign run = ~off_flat & ~({FLAT_W{off_flat[SYS_CLOCK_GATE_OFF]}}
               & SYSCLK_USERS);

  pmd_clk_gate #(
    .W (FLAT_W)
  ) u_gate (
    .i_clock  (i_clock),
    .i_reset  (i_reset),
    .i_run    (run),
    .o_clk_en (o_mod_clk_en)
  );

  // ----------------------------------------------------------------
  // Peripheral register gating
  // ----------------------------------------------------------------
  logic sel_off;

  assign sel_off = (i_sfr_sel < 6'(FLAT_W)) ? off_flat[i_sfr_sel] : 1'b0;

  // Disabled module: writes dropped, reads zero
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_sfr_we    <= 1'b0;
      o_sfr_rdata <= SFR_ZERO;
    end else begin
      o_sfr_we    <= i_sfr_we && !sel_off;
      o_sfr_rdata <= sel_off ? SFR_ZERO : i_sfr_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Memory controller gating
  // ----------------------------------------------------------------
  logic mem_off;

  assign mem_off = off_flat[MEMORY_CTRL_OFF];

  // Software must allow the controller to settle after re-enable
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_mem_rd      <= 1'b0;
      o_mem_wr      <= 1'b0;
      o_mem_ctrl_we <= 1'b0;
      o_mem_rdata   <= SFR_ZERO;
    end else begin
      o_mem_rd      <= i_mem_rd && !mem_off;
      o_mem_wr      <= i_mem_wr && !mem_off;
      o_mem_ctrl_we <= i_mem_ctrl_we && !mem_off;
      o_mem_rdata   <= mem_off ? SFR_ZERO : i_mem_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  wb_ack_pulse_a: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("Ack held longer than one cycle");

  wb_ack_timing_a: assert property (
    bus_req && !o_wb_ack && bus_q == PMD_BUS_IDLE |=> o_wb_ack)
    else $error("Request not acked next cycle");

  unimpl_zero_a: assert property (
    ((ctrl_q[0] & ~CTRL0_MASK) == 8'h00)
    && ((ctrl_q[4] & ~CTRL4_MASK) == 8'h00))
    else $error("Unimplemented bit holds a one");

  write_lands_a: assert property (
    wr_take && acc_idx == 3'h3 |=>
      ctrl_q[3] == ($past(i_wb_dat[7:0]) & CTRL3_MASK))
    else $error("Write did not land in control register");

  clk_gate_follow_a: assert property (
    off_flat[SYS_CLOCK_GATE_OFF] |->
      (!o_mod_clk_en[TIMER1_OFF] || !SYSCLK_USERS[TIMER1_OFF])
      ##1 o_sys_clock_gate_off)
    else $error("System clock gate did not stop users");

  hold_reset_a: assert property (
    off_flat[ADC_OFF] ##1 off_flat[ADC_OFF] |->
      o_mod_reset[ADC_OFF] && o_pin_route_off[ADC_OFF])
    else $error("Disabled module not held in reset");

  sfr_read_zero_a: assert property (
    sel_off |=> o_sfr_rdata == SFR_ZERO && !o_sfr_we)
    else $error("Disabled module register not blocked");

  mem_block_a: assert property (
    mem_off && (i_mem_rd || i_mem_wr || i_mem_ctrl_we) |=>
      !o_mem_rd && !o_mem_wr && !o_mem_ctrl_we
      && o_mem_rdata == SFR_ZERO)
    else $error("Memory access passed while controller off");

  mem_pass_a: assert property (
    !mem_off && i_mem_rd |=> o_mem_rd && o_mem_rdata == $past(i_mem_rdata))
    else $error("Memory read blocked while controller on");

  gate_no_self_a: assert property (
    ##1 !o_mod_reset[SYS_CLOCK_GATE_OFF])
    else $error("Gate bit held a module in reset");

  cover_write_c: cover property (wr_take ##1 o_wb_ack);
  cover_gate_c: cover property (off_flat[SYS_CLOCK_GATE_OFF] ##2
                                o_sys_clock_gate_off);
  cover_reenable_c: cover property (off_flat[TIMER1_OFF] ##1
                                    !off_flat[TIMER1_OFF]);
  cover_mem_block_c: cover property (mem_off && i_mem_wr);

endmodule

// [sim/pmd_top_tb.sv]
// Self-checking bench for the peripheral module disable block.
// Assumes the package constants and a single 250 MHz clock domain.
`timescale 1ns/1ps
module pmd_top_tb
  import pmd_pkg::*;
;
  // ----------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------
  // Timer0 left off the system clock net so the gate bit must spare it
  localparam logic [FLAT_W-1:0] USERS =
    SYSCLK_USERS_DEFAULT & ~(40'h1 << TIMER0_OFF);
  localparam int MAX_CYC = 5000;
  typedef struct packed {
    logic [4:0] adr;
    logic [7:0] wd;
    logic [7:0] rd;
  } pmd_row_t;

  logic              i_clock;
  logic              i_reset;
  logic              i_wb_cyc, i_wb_stb, i_wb_we;
  logic [4:0]        i_wb_adr;
  logic [3:0]        i_wb_sel;
  logic [31:0]       i_wb_dat, o_wb_dat;
  logic              o_wb_ack;
  logic [5:0]        i_sfr_sel;
  logic              i_sfr_we, o_sfr_we;
  logic [7:0]        i_sfr_rdata, o_sfr_rdata;
  logic              i_mem_rd, i_mem_wr, i_mem_ctrl_we;
  logic              o_mem_rd, o_mem_wr, o_mem_ctrl_we;
  logic [7:0]        i_mem_rdata, o_mem_rdata;
  logic [FLAT_W-1:0] o_mod_reset, o_mod_clk_en, o_pin_route_off;
  logic              o_sys_clock_gate_off;
  logic [31:0]       rd;
  logic [39:0]       flat;
  logic              gate;
  int                idx, error_cnt, tests_run, cyc_cnt;
  pmd_row_t          rows [11];

  pmd_top #(.SYSCLK_USERS(USERS)) pmd_top_i (
    .i_clock(i_clock), .i_reset(i_reset),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_sfr_sel(i_sfr_sel), .i_sfr_we(i_sfr_we),
    .i_sfr_rdata(i_sfr_rdata), .o_sfr_we(o_sfr_we),
    .o_sfr_rdata(o_sfr_rdata), .i_mem_rd(i_mem_rd),
    .i_mem_wr(i_mem_wr), .i_mem_ctrl_we(i_mem_ctrl_we),
    .i_mem_rdata(i_mem_rdata), .o_mem_rd(o_mem_rd),
    .o_mem_wr(o_mem_wr), .o_mem_ctrl_we(o_mem_ctrl_we),
    .o_mem_rdata(o_mem_rdata), .o_mod_reset(o_mod_reset),
    .o_mod_clk_en(o_mod_clk_en), .o_pin_route_off(o_pin_route_off),
    .o_sys_clock_gate_off(o_sys_clock_gate_off));

  // Clock and hang guard
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == MAX_CYC) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask

  // One classic cycle; ack and data taken at the rising edge, only the
  // hang guard ends a wait that never sees ack
  task automatic wb(input logic we, input logic [4:0] adr,
                    input logic [7:0] wd, input logic [3:0] sel);
    @(posedge i_clock);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= adr;
    i_wb_sel <= sel;
    i_wb_dat <= {24'h0, wd};
    do begin
      @(posedge i_clock);
    end while (o_wb_ack !== 1'b1);
    chk("wb ack", 40'(o_wb_ack), 40'h1);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we  <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel, i_wb_dat} = '0;
    {i_sfr_sel, i_sfr_we, i_sfr_rdata} = '0;
    {i_mem_rd, i_mem_wr, i_mem_ctrl_we, i_mem_rdata} = '0;
    {error_cnt, tests_run, cyc_cnt} = '0;
    i_reset = 1'b1;
    // Each register: all ones, then only unimplemented bits; register 0 also gets bit 7 alone in between
    rows = '{'{5'h00, 8'hff, 8'hc7}, '{5'h00, 8'h80, 8'h80},
             '{5'h00, 8'h38, 8'h00}, '{5'h04, 8'hff, 8'h87},
             '{5'h04, 8'h78, 8'h00}, '{5'h08, 8'hff, 8'h67},
             '{5'h08, 8'h98, 8'h00}, '{5'h0c, 8'hff, 8'h3f},
             '{5'h0c, 8'hc0, 8'h00}, '{5'h10, 8'hff, 8'hd1},
             '{5'h10, 8'h2e, 8'h00}};
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      wb(1'b0, 5'(4 * i), 8'h00, 4'h1);
      chk("reset value", 40'(rd), 40'h0);
    end
    chk("clk_en at reset", o_mod_clk_en, '1);
    // Table of ordinary writes; every disable bit set and cleared
    for (int r = 0; r < 11; r++) begin
      idx = int'(rows[r].adr) / 4;
      wb(1'b1, rows[r].adr, rows[r].wd, 4'h1);
      wb(1'b0, rows[r].adr, 8'h00, 4'h1);
      chk("readback", 40'(rd), 40'(rows[r].rd));
      flat = 40'(rows[r].rd) << (8 * idx);
      gate = flat[SYS_CLOCK_GATE_OFF];
      flat[SYS_CLOCK_GATE_OFF] = 1'b0;
      chk("mod_reset", o_mod_reset, flat);
      chk("pin_route", o_pin_route_off, flat);
      chk("clk_en", o_mod_clk_en, ~(flat | (gate ? USERS : '0)
          | (40'(gate) << SYS_CLOCK_GATE_OFF)));
      chk("sys gate", 40'(o_sys_clock_gate_off), 40'(gate));
      chk("bit 7 hold", 40'(o_mod_reset[7]), 40'h0);
    end
    // Lane 0 off and unmapped places: writes must not land
    wb(1'b1, CTRL1_ADDR, 8'hff, 4'he);
    wb(1'b0, CTRL1_ADDR, 8'h00, 4'h1);
    chk("sel0 write", 40'(rd), 40'h0);
    wb(1'b1, 5'h14, 8'hff, 4'h1);
    wb(1'b0, 5'h14, 8'h00, 4'h1);
    chk("unmapped", 40'(rd), 40'h0);
    chk("unmapped side", o_mod_reset, 40'h0);
    // Memory and peripheral register gating: open, memory off, timer1 off
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, CTRL0_ADDR, (k == 1) ? 8'h04 : 8'h00, 4'h1);
      wb(1'b1, CTRL1_ADDR, (k == 2) ? 8'h02 : 8'h00, 4'h1);
      // Settle time after a re-enable: 1 us of 4 ns cycles
      repeat (250) @(posedge i_clock);
      i_mem_rd      <= 1'b1;
      i_mem_wr      <= 1'b1;
      i_mem_ctrl_we <= 1'b1;
      i_mem_rdata   <= 8'h5a + 8'(k);
      i_sfr_sel     <= 6'(TIMER1_OFF);
      i_sfr_we      <= 1'b1;
      i_sfr_rdata   <= 8'h3c + 8'(k);
      @(posedge i_clock);
      @(negedge i_clock);
      chk("mem_rd", 40'(o_mem_rd), 40'(k != 1));
      chk("mem_wr", 40'(o_mem_wr), 40'(k != 1));
      chk("mem ctrl we", 40'(o_mem_ctrl_we), 40'(k != 1));
      chk("mem data", 40'(o_mem_rdata), (k == 1) ? 40'h0 : 40'h5a + k);
      chk("sfr we", 40'(o_sfr_we), 40'(k != 2));
      chk("sfr data", 40'(o_sfr_rdata), (k == 2) ? 40'h0 : 40'h3c + k);
      @(posedge i_clock);
      {i_mem_rd, i_mem_wr, i_mem_ctrl_we, i_sfr_we} <= '0;
    end
    // Reset in mid-run with disable bits set
    wb(1'b1, CTRL3_ADDR, 8'hff, 4'h1);
    wb(1'b1, CTRL4_ADDR, 8'hff, 4'h1);
    i_reset <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      wb(1'b0, 5'(4 * i), 8'h00, 4'h1);
      chk("rereset value", 40'(rd), 40'h0);
    end
    chk("rereset clk_en", o_mod_clk_en, '1);
    chk("rereset hold", o_mod_reset, 40'h0);
    wrap_up();
  end
endmodule
